// File: logic/rtcvs_defines.vh
// Constants for the validity status and battery RAM block
`ifndef RTCVS_DEFINES_VH
`define RTCVS_DEFINES_VH
`define RTCVS_IO_INDEX_PORT 16'h0070
`define RTCVS_IO_DATA_PORT 16'h0071
`define RTCVS_IDX_STATUS 7'h0D
`define RTCVS_IDX_RAM_FIRST 7'h0E
`define RTCVS_IDX_RAM_LAST 7'h7F
`define RTCVS_RAM_BYTES 114
`define RTCVS_RAM_AW 7
`define RTCVS_VALID_BIT 7
`define RTCVS_INDEX_RESET 7'h00
`define RTCVS_RESERVED_READ 7'h00
`define RTCVS_IDLE_DATA 8'h00
`define RTCVS_UNMAPPED_DATA 8'hFF
`endif

// File: logic/rtcvs_ram.v
// Battery-backed general-purpose byte store with registered read data
module rtcvs_ram (
  // Clock
  input wire clk,
  // Access
  input wire [6:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data_q
);

  reg [7:0] mem [0:127];

  // Locations below the first RAM index are never written; no reset keeps contents
  always @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data_q <= mem[addr];
  end

endmodule // rtcvs_ram

// File: logic/rtcvs_top.v
// Validity status register and battery RAM behind the index/data port pair
//
// Function
// RL1: Status register at index 0Dh, bit 7 is a read-only validity flag.
// RL2: Flag 0 means time, date and RAM contents are invalid.
// RL3: Validity flag clears to 0 on every clock-only reset.
// RL4: Reading the status register sets the flag; stays set until next clock-only reset. The code also clears it on sys_rst.
// RL5: Clock-only reset when battery sense is low during power-on reset.
// RL6: Flag is latched, not a live battery indication.
// RL7: Software writes zeros to reserved status bits 6 to 0.
// RL8: 114 general RAM bytes at indexes 0E to 7Fh, read and write.
// RL9: RAM access ignores clock updates and date format.
// RL10: Disabled clock unit blocks RAM access but keeps contents.
// RL11: Index written at port 70h, data accessed at port 71h.
`include "rtcvs_defines.vh"

module rtcvs_top (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Power-on reset qualification
  input wire power_on_reset,
  input wire backup_battery_sense,
  // Configuration from address decode control
  input wire clock_unit_disable,
  input wire date_format_binary,
  // I/O port access
  input wire [15:0] io_addr,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_q,
  output reg io_rvalid_q,
  // Status out
  output reg clock_only_reset_q,
  output reg time_and_ram_valid_flag_q
);

  // ****************************************
  // Helpers
  // ****************************************
  function is_ram_index;
    input [6:0] idx;
    begin
      is_ram_index = (idx >= `RTCVS_IDX_RAM_FIRST) && (idx <= `RTCVS_IDX_RAM_LAST);
    end
  endfunction

  // ****************************************
  // Port decode
  // ****************************************
  reg [6:0] index_q;
  reg [6:0] index_d;
  reg rd_pend_q;
  reg rd_ram_q;
  wire sel_index = (io_addr == `RTCVS_IO_INDEX_PORT); // RL11
  wire sel_data = (io_addr == `RTCVS_IO_DATA_PORT); // RL11
  wire data_rd = sel_data && io_rd;
  wire data_wr = sel_data && io_wr;
  wire status_rd = data_rd && (index_q == `RTCVS_IDX_STATUS); // RL1
  // Disabled unit hides the RAM; contents simply stay where they are
  wire ram_ok = is_ram_index(index_q) && !clock_unit_disable; // RL10
  wire ram_wr = data_wr && ram_ok; // RL8
  wire [7:0] ram_rdata;
  wire unused_format = date_format_binary; // RL9

  always @* begin
    index_d = index_q;
    if (sel_index && io_wr) begin
      index_d = io_wdata[6:0]; // RL11
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      index_q <= `RTCVS_INDEX_RESET;
    end else begin
      index_q <= index_d;
    end
  end

  // ****************************************
  // Clock-only reset and validity flag
  // ****************************************
  // Battery sense is only looked at while power-on reset is asserted
  wire rtc_only_rst = power_on_reset && !backup_battery_sense; // RL5

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_only_reset_q <= 1'b0;
      time_and_ram_valid_flag_q <= 1'b0;
    end else begin
      clock_only_reset_q <= rtc_only_rst; // RL5
      if (rtc_only_rst) begin
        time_and_ram_valid_flag_q <= 1'b0; // RL3 RL2
      end else if (status_rd) begin
        time_and_ram_valid_flag_q <= 1'b1; // RL4 RL6
      end
    end
  end

  // ****************************************
  // Battery RAM
  // ****************************************
  // Writes with the format bit in any state store the byte untouched
  rtcvs_ram u_ram (
    .clk(clk),
    .addr(index_q),
    .wr_en(ram_wr),
    .wr_data(io_wdata),
    .rd_data_q(ram_rdata)
  ); // RL8 RL9

  // ****************************************
  // Read return
  // ****************************************
  // Status read returns the flag as it was before this read sets it
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_q <= 1'b0;
      rd_ram_q <= 1'b0;
      io_rdata_q <= `RTCVS_IDLE_DATA;
      io_rvalid_q <= 1'b0;
    end else begin
      rd_pend_q <= data_rd && ram_ok;
      rd_ram_q <= data_rd && ram_ok;
      io_rvalid_q <= 1'b0;
      if (status_rd) begin
        io_rdata_q <= {time_and_ram_valid_flag_q, `RTCVS_RESERVED_READ}; // RL1 RL7
        io_rvalid_q <= 1'b1;
      end else if (rd_pend_q && rd_ram_q) begin
        io_rdata_q <= ram_rdata; // RL8
        io_rvalid_q <= 1'b1;
      end else if (data_rd && !ram_ok) begin
        io_rdata_q <= `RTCVS_UNMAPPED_DATA; // RL10
        io_rvalid_q <= 1'b1;
      end else if (sel_index && io_rd) begin
        io_rdata_q <= {1'b0, index_q};
        io_rvalid_q <= 1'b1;
      end
    end
  end

endmodule // rtcvs_top

// File: verification/rtcvs_props.sv
// Assertion checker for the status and RAM block
module rtcvs_props (
  input wire logic clk, sys_rst, power_on_reset, backup_battery_sense, io_rd, io_rvalid_q,
  input wire logic clock_only_reset_q, time_and_ram_valid_flag_q,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_rdata_q
);
  wire f = time_and_ram_valid_flag_q, r = clock_only_reset_q;
  wire l = power_on_reset && !backup_battery_sense, d = io_rd && io_addr == 16'h0071;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_low_reset: assert property (l |=> r) else $error("r");
  chk_no_reset: assert property (!l |=> !r) else $error("r");
  chk_flag_clear: assert property (r |-> ##[0:1] !f) else $error("f");
  chk_flag_kept: assert property ($fell(f) |-> r || $past(r)) else $error("f");
  chk_flag_set: assert property ($rose(f) |-> $past(d)) else $error("f");
  chk_flag_still: assert property (!l && !r && !io_rd |=> $stable(f)) else $error("f");
  chk_read_answer: assert property (d |-> ##[1:2] io_rvalid_q) else $error("v");
  chk_answer_cause: assert property (io_rvalid_q |-> $past(io_rd) || $past(io_rd, 2))
    else $error("v");
  cover property (r);
  cover property ($rose(f));
  cover property (io_rvalid_q && io_rdata_q == 8'hFF);
endmodule // rtcvs_props
bind rtcvs_top rtcvs_props i_rtcvs_props (.*);

// File: verification/rtcvs_tb_top.sv
// Bench for the status and RAM block
module rtcvs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, por = 1, bat = 0, dis = 0, fmt = 0, rd = 0, wr = 0, rv, cr, fv;
  logic [15:0] a = 16'h0000;
  logic [7:0] wd = 8'h00, q, e, mem [128];
  int errors = 0, n_checks = 0, cyc = 0, vf = 0, i;
  rtcvs_top i_rtcvs_top (.clk, .sys_rst, .power_on_reset(por), .backup_battery_sense(bat),
    .clock_unit_disable(dis), .date_format_binary(fmt), .io_addr(a), .io_rd(rd), .io_wr(wr),
    .io_wdata(wd), .io_rdata_q(q), .io_rvalid_q(rv), .clock_only_reset_q(cr),
    .time_and_ram_valid_flag_q(fv));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 5000) begin
    errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("n_checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] w);
    n_checks++;
    if (g !== w) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, g, w);
    end
  endtask
  // Index write then data access; status read returns the flag before it sets
  task automatic acc(input logic w, input logic [6:0] x, input logic [7:0] d);
    e = x == 7'h0D ? {vf[0], 7'h00} : x > 7'h0D && !dis ? mem[x] : 8'hFF;
    vf = !w && x == 7'h0D ? 1 : vf;
    if (w && x > 7'h0D && !dis) mem[x] = d;
    @(negedge clk) {wr, a, wd} = {1'h1, 16'h0070, 1'h0, x};
    @(negedge clk) {wr, rd, a, wd} = {w, !w, 16'h0071, d};
    @(negedge clk) {wr, rd} = 2'h0;
    repeat (3) if (!w && rv !== 1'h1) @(posedge clk) #1;
    n_checks += !w;
    if (!w && (rv !== 1'h1 || q !== e)) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, q, e);
    end
    cmp({7'h00, fv}, {7'h00, vf[0]});
  endtask
  initial begin
    void'($urandom(32'h8542));
    repeat (10) @(negedge clk);
    sys_rst = 0;
    repeat (3) @(negedge clk);
    por = 0;
    acc(0, 7'h0D, 8'h00);
    acc(0, 7'h0D, 8'h00);
    bat = 0;
    acc(1, 7'h0D, 8'h00);
    acc(0, 7'h0D, 8'h00);
    for (i = 14; i < 256; i++) begin
      fmt = i[0];
      acc(i < 128, i[6:0], 8'($urandom));
    end
    dis = 1;
    acc(1, 7'h7F, 8'hA5);
    acc(0, 7'h7F, 8'h00);
    dis = 0;
    acc(0, 7'h7F, 8'h00);
    bat = 1;
    por = 1;
    repeat (3) @(negedge clk);
    cmp({7'h00, cr}, 8'h00);
    por = 0;
    acc(0, 7'h0D, 8'h00);
    bat = 0;
    por = 1;
    repeat (3) @(negedge clk);
    cmp({7'h00, cr}, 8'h01);
    por = 0;
    vf = 0;
    acc(0, 7'h0D, 8'h00);
    report_and_stop();
  end
endmodule // rtcvs_tb_top
